// ==== verification/acc_ana_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module acc_ana_model (
   input  wire logic              i_mclk,
   input  var  acc_pkg::acc_ana_t i_ana,
   output logic                   o_cmp
);
   import acc_pkg::*;
   logic [9:0] level;
   logic       wander_q;
   // Every pin is taken as analog-configured with its driver off
   // Each source, temperature and reference included, has its own level
   assign level = {i_ana.chan, ~i_ana.chan};
   initial wander_q = 1'b0;
   // While tracking the comparator means nothing, so it must not look settled
   always @(posedge i_mclk) begin
      wander_q <= ~wander_q;
   end
   assign o_cmp = i_ana.sample ? wander_q : (level >= i_ana.code);
endmodule
`default_nettype wire

// ==== verification/test_adc_conversion_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_adc_conversion_control;
   import acc_pkg::*;
   localparam int ACQ       = 20;
   localparam int TEMP_WAIT = 4000;
   localparam int LIMIT     = 60000;
   logic        i_mclk, i_sys_rst, i_hsel, i_hwrite, i_rc_osc, i_sleep, cmp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata;
   logic [1:0]  i_htrans;
   logic [2:0]  i_hsize;
   logic        o_hreadyout, o_hresp, o_conv_active, o_irq, o_wake;
   acc_ana_t    ana;
   int          failures = 0;
   int          checks   = 0;
   int          cyc      = 0;

   acc_ctrl u_dut (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .o_hrdata(o_hrdata), .i_rc_osc(i_rc_osc), .i_cmp(cmp), .i_sleep(i_sleep),
      .o_ana(ana), .o_conv_active(o_conv_active), .o_irq(o_irq), .o_wake(o_wake)
   );
   acc_ana_model u_ana (.i_mclk(i_mclk), .i_ana(ana), .o_cmp(cmp));

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   // Odd half period keeps the oscillator out of step with the system clock
   initial begin
      i_rc_osc = 1'b0;
      forever #501 i_rc_osc = ~i_rc_osc;
   end

   task automatic give_verdict();
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      @(posedge i_mclk);
      i_hsel   <= 1'b1;
      i_haddr  <= {24'h00_0000, a};
      i_htrans <= 2'b10;
      i_hwrite <= wr;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_hsel   <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      q = o_hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0000_0000, q);
      check(what, q, exp);
   endtask

   // Enable goes in first: a start written together with enable is ignored
   task automatic start(input logic [4:0] ch, input logic [2:0] cs, input logic fmt, input int acq);
      wr(OFS_CTRL1, {24'h00_0000, fmt, cs, 4'h0});
      wr(OFS_CTRL0, {25'h000_0000, ch, 2'b01});
      repeat (acq) @(posedge i_mclk);
      wr(OFS_CTRL0, {25'h000_0000, ch, 2'b11});
   endtask

   task automatic wait_done(output int n);
      n = 0;
      @(posedge i_mclk);
      while (o_conv_active === 1'b1 && n < 3000) begin
         n++;
         @(posedge i_mclk);
      end
   endtask

   task automatic results(input logic [4:0] ch, input logic fmt);
      logic [9:0]  v;
      logic [31:0] hi;
      logic [31:0] lo;
      v  = {ch, ~ch};
      hi = fmt ? {24'h00_0000, 6'h00, v[9:8]} : {24'h00_0000, v[9:2]};
      lo = fmt ? {24'h00_0000, v[7:0]} : {24'h00_0000, v[1:0], 6'h00};
      rd_chk("result_high_reg", OFS_RES_HI, hi);
      rd_chk("result_low_reg", OFS_RES_LO, lo);
      check("code_sample", {ana.sample, ana.code}, {1'b1, v});
      check("bus_resp", {o_hreadyout, o_hresp}, 2'b10);
   endtask

   initial begin
      int         n;
      int         lo;
      int         hi;
      logic [2:0] cs;
      logic [4:0] ch;
      i_sys_rst = 1'b1;
      i_hsel    = 1'b0;
      i_haddr   = 32'h0000_0000;
      i_htrans  = 2'b00;
      i_hwrite  = 1'b0;
      i_hsize   = 3'b010;
      i_hwdata  = 32'h0000_0000;
      i_sleep   = 1'b0;
      repeat (16) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      wr(OFS_FLAG, 32'h0000_0001);
      wr(OFS_RES_HI, 32'hffff_ffff);
      wr(8'h18, 32'hffff_ffff);
      for (int a = 0; a <= 24; a += 4) begin
         rd_chk("reset_or_refused", 8'(a), 32'h0000_0000);
      end
      for (int p = 0; p < 4; p++) begin
         wr(OFS_CTRL1, 32'(p));
         @(posedge i_mclk);
         check("pref", ana.pref, (2'(p) == REF_RSVD) ? REF_VDD : 2'(p));
      end
      // Every clock select code, both result formats along the way
      for (int k = 0; k < 8; k++) begin
         cs = 3'(k);
         ch = 5'(k * 4 + 1);
         start(ch, cs, cs[0], ACQ);
         check("chan", ana.chan, ch);
         wait_done(n);
         // First tick lands anywhere within the first half period
         lo = (cs[1:0] == 2'b11) ? 220 : (22 << {cs[1:0], cs[2]}) + 1;
         hi = (cs[1:0] == 2'b11) ? 234 : 23 << {cs[1:0], cs[2]};
         check("busy_len", n >= lo && n <= hi, 1);
         rd_chk("go_clear", OFS_CTRL0, {25'h000_0000, ch, 2'b01});
         results(ch, cs[0]);
         rd_chk("flag", OFS_FLAG, 32'h0000_0001);
         check("irq_masked", o_irq, 1'b0);
         wr(OFS_FLAG, 32'h0000_0000);
         rd_chk("flag_clr", OFS_FLAG, 32'h0000_0000);
      end
      start(CH_TEMP, CS_DIV4, 1'b1, TEMP_WAIT);
      check("temp_sel", ana.temp_sel, 1'b1);
      wait_done(n);
      results(CH_TEMP, 1'b1);
      repeat (TEMP_WAIT) @(posedge i_mclk);
      wr(OFS_CTRL0, {25'h000_0000, CH_TEMP, 2'b11});
      wait_done(n);
      results(CH_TEMP, 1'b1);
      start(CH_FVR, CS_DIV4, 1'b0, ACQ);
      check("fvr_sel", ana.fvr_sel, 1'b1);
      wait_done(n);
      results(CH_FVR, 1'b0);
      // Software abort before any decision leaves an all-zero partial result
      start(5'h02, 3'b110, 1'b1, ACQ);
      wr(OFS_CTRL0, {25'h000_0000, 5'h02, 2'b01});
      rd_chk("abort_hi", OFS_RES_HI, 32'h0000_0000);
      rd_chk("abort_lo", OFS_RES_LO, 32'h0000_0000);
      rd_chk("abort_go", OFS_CTRL0, {25'h000_0000, 5'h02, 2'b01});
      rd_chk("abort_flag", OFS_FLAG, 32'h0000_0001);
      // Sleep with a divided clock must kill the conversion
      start(5'h02, 3'b110, 1'b1, ACQ);
      wr(OFS_FLAG, 32'h0000_0000);
      i_sleep <= 1'b1;
      wait_done(n);
      check("sleep_abort", n <= 4, 1);
      rd_chk("no_flag", OFS_FLAG, 32'h0000_0000);
      wr(OFS_IEN, 32'h0000_0001);
      start(5'h03, 3'b111, 1'b0, ACQ);
      check("irq_noflag", o_irq, 1'b0);
      wait_done(n);
      @(posedge i_mclk);
      check("wake", o_wake, 1'b1);
      results(5'h03, 1'b0);
      i_sleep <= 1'b0;
      @(posedge i_mclk);
      check("wake_off", {o_wake, o_irq}, 2'b01);
      wr(OFS_FLAG, 32'h0000_0000);
      @(posedge i_mclk);
      check("irq_clr", o_irq, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire

// ==== verilog/acc_ctrl.sv ====
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RQ1: One channel code reserved for temperature indicator
// RQ2: Software waits 200 us after selecting temperature
// RQ3: Software spaces temperature conversions by 200 us
// RQ4: Ten-bit successive approximation into result pair
// RQ5: Channel field selects one of thirty sources
// RQ6: Software waits acquisition delay after channel change
// RQ7: Reference field selects upper converter reference
// RQ8: Clock field picks divider tap or RC
// RQ9: Conversion lasts 11.5 bit periods
// RQ10: Divided clocks track system clock; RC independent
// RQ11: Sleep keeps converting only with RC clock
// RQ12: Completion always sets the complete flag
// RQ13: Flag cleared only by software
// RQ14: Interrupt needs flag and enable both set
// RQ15: Enabled interrupt in sleep wakes device
// RQ16: Format bit selects left or right justification
// RQ17: Software configures pin analog before converting
// RQ18: Codes 11110, 11111 route temperature and reference
// RQ19: Unused six result bits load as zero
// RQ20: Go bit starts; hardware clears it at completion
// RQ21: Both result registers update in one cycle
// RQ22: Free-running counter tap gives bit-period ticks; here each tap tick is half a bit period
module acc_ctrl (
   input  wire logic               i_mclk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_hsel,
   input  wire logic [31:0]        i_haddr,
   input  wire logic [1:0]         i_htrans,
   input  wire logic               i_hwrite,
   input  wire logic [2:0]         i_hsize,
   input  wire logic [31:0]        i_hwdata,
   input  wire logic               i_hready,
   output logic                    o_hreadyout,
   output logic                    o_hresp,
   output logic [31:0]             o_hrdata,
   input  wire logic               i_rc_osc,
   input  wire logic               i_cmp,
   input  wire logic               i_sleep,
   output var acc_pkg::acc_ana_t   o_ana,
   output logic                    o_conv_active,
   output logic                    o_irq,
   output logic                    o_wake
);
   import acc_pkg::*;

   acc_ctrl0_t        ctrl0_q;
   acc_ctrl1_t        ctrl1_q;
   acc_state_t        st_q;
   logic              rc_s1_q;
   logic              rc_s2_q;
   logic              rc_s3_q;
   logic [DIV_W-1:0]  div_cnt_q;
   logic              wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [4:0]        half_q;
   logic [RES_W-1:0]  trial_q;
   logic [RES_W-1:0]  mask_q;
   logic              last_q;
   logic [7:0]        res_hi_q;
   logic [7:0]        res_lo_q;
   logic              flag_q;
   logic              ien_q;
   logic              accept;
   logic              mapped;
   logic              wr_c0;
   logic              wr_c1;
   logic              wr_flag;
   logic              wr_ien;
   logic              rc_sel;
   logic              rc_edge;
   logic [2:0]        tap;
   logic [5:0]        tap_one;
   logic [DIV_W-1:0]  tap_mask;
   logic              tick;
   logic              start;
   logic              abort_sw;
   logic              abort_off;
   logic              decide;
   logic              done;
   logic              res_upd;
   logic [RES_W-1:0]  trial_dec;
   logic [RES_W-1:0]  low_bits;
   logic [RES_W-1:0]  partial;
   logic [RES_W-1:0]  res_val;
   logic              flag_clr;

   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // Bus address phase
   assign accept = i_hsel && i_htrans[1] && i_hready;
   assign mapped = (i_haddr[31:5] == 27'h000_0000) && (i_haddr[1:0] == 2'h0);

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_q   <= 1'b0;
         addr_q <= OFS_CTRL0;
      end else begin
         wr_q   <= accept && i_hwrite && mapped;
         addr_q <= i_haddr[ADDR_W-1:0];
      end
   end

   assign wr_c0   = wr_q && (addr_q == OFS_CTRL0);
   assign wr_c1   = wr_q && (addr_q == OFS_CTRL1);
   assign wr_flag = wr_q && (addr_q == OFS_FLAG);
   assign wr_ien  = wr_q && (addr_q == OFS_IEN);

   // Read data is loaded at the address phase; unmapped reads zero
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_hrdata <= RD_ZERO;
      end else if (accept && !i_hwrite) begin
         o_hrdata <= RD_ZERO;
         if (mapped) begin
            unique case (i_haddr[ADDR_W-1:0])
               OFS_CTRL0: begin
                  o_hrdata[C0_CHS_MSB:C0_CHS_LSB] <= ctrl0_q.chan;
                  o_hrdata[C0_GO]                 <= (st_q == ST_CONV);
                  o_hrdata[C0_EN]                 <= ctrl0_q.en;
               end
               OFS_CTRL1: begin
                  o_hrdata[C1_FMT]                <= ctrl1_q.fmt;
                  o_hrdata[C1_CS_MSB:C1_CS_LSB]   <= ctrl1_q.clksel;
                  o_hrdata[C1_REF_MSB:C1_REF_LSB] <= ctrl1_q.pref;
               end
               OFS_RES_HI: o_hrdata[7:0] <= res_hi_q;
               OFS_RES_LO: o_hrdata[7:0] <= res_lo_q;
               OFS_FLAG:   o_hrdata[FLG_BIT] <= flag_q;
               OFS_IEN:    o_hrdata[IEN_BIT] <= ien_q;
               default:    o_hrdata <= RD_ZERO;
            endcase
         end
      end
   end

   // Configuration registers
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl0_q <= '{chan: RST_CHAN, en: 1'b0};
         ctrl1_q <= '{fmt: 1'b0, clksel: RST_CS, pref: RST_REF};
         ien_q   <= 1'b0;
      end else begin
         if (wr_c0) begin
            ctrl0_q.chan <= i_hwdata[C0_CHS_MSB:C0_CHS_LSB]; // [RQ5]
            ctrl0_q.en   <= i_hwdata[C0_EN];
         end
         if (wr_c1) begin
            ctrl1_q.fmt    <= i_hwdata[C1_FMT];
            ctrl1_q.clksel <= i_hwdata[C1_CS_MSB:C1_CS_LSB];
            ctrl1_q.pref   <= i_hwdata[C1_REF_MSB:C1_REF_LSB];
         end
         if (wr_ien) begin
            ien_q <= i_hwdata[IEN_BIT];
         end
      end
   end

   // RC oscillator synchroniser; it is slow enough to be sampled
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rc_s1_q  <= 1'b0;
         rc_s2_q  <= 1'b0;
         rc_s3_q  <= 1'b0;
      end else begin
         rc_s1_q  <= i_rc_osc;
         rc_s2_q  <= rc_s1_q;
         rc_s3_q  <= rc_s2_q;
      end
   end

   // Free-running divider; each tick is half a bit period
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_q + 5'h01; // [RQ22] [RQ10]
      end
   end

   assign rc_sel   = (ctrl1_q.clksel[1:0] == CS_RC);
   assign rc_edge  = rc_s2_q ^ rc_s3_q;
   assign tap      = {ctrl1_q.clksel[1:0], ctrl1_q.clksel[2]};
   assign tap_one  = 6'h01 << tap;
   assign tap_mask = tap_one[DIV_W-1:0] - 5'h01;
   // Both RC edges count, so the RC bit period is one RC cycle
   assign tick = rc_sel ? rc_edge : (&(div_cnt_q | ~tap_mask)); // [RQ8] [RQ22]

   // Conversion sequencing
   assign start     = wr_c0 && i_hwdata[C0_GO] && i_hwdata[C0_EN] && ctrl0_q.en
                      && (st_q == ST_IDLE) && !(i_sleep && !rc_sel); // [RQ20]
   assign abort_sw  = wr_c0 && !i_hwdata[C0_GO] && (st_q == ST_CONV);
   assign abort_off = (st_q == ST_CONV)
                      && ((wr_c0 && !i_hwdata[C0_EN]) || (i_sleep && !rc_sel)); // [RQ11]
   assign decide    = (st_q == ST_CONV) && tick && (half_q >= HALF_DEC0) && !half_q[0];
   assign done      = (st_q == ST_CONV) && tick && (half_q == HALF_LAST)
                      && !abort_sw && !abort_off; // [RQ9]
   assign res_upd   = done || (abort_sw && !abort_off);

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (start) begin
                  st_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (done || abort_sw || abort_off) begin
                  st_q <= ST_IDLE; // [RQ20]
               end
            end
         endcase
      end
   end

   // Successive approximation register
   // Comparator follows the registered trial code within one cycle;
   // a synchroniser here would feed the fastest tap stale answers
   assign trial_dec = i_cmp ? trial_q : (trial_q & ~mask_q);
   assign low_bits  = mask_q | (mask_q - 10'h001);
   // Aborted: unresolved bits copy the last bit decided
   assign partial   = (trial_q & ~low_bits) | (last_q ? low_bits : '0);
   assign res_val   = done ? trial_dec : partial;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         half_q  <= '0;
         trial_q <= '0;
         mask_q  <= '0;
         last_q  <= 1'b0;
      end else if (start) begin
         half_q  <= '0;
         trial_q <= SAR_MSB;
         mask_q  <= SAR_MSB;
         last_q  <= 1'b0;
      end else if ((st_q == ST_CONV) && tick) begin
         half_q <= half_q + 5'h01;
         if (decide) begin
            trial_q <= trial_dec | (mask_q >> 1); // [RQ4]
            mask_q  <= mask_q >> 1;
            last_q  <= i_cmp;
         end
      end
   end

   // Results
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         res_hi_q <= RST_RES;
         res_lo_q <= RST_RES;
      end else if (res_upd) begin
         if (ctrl1_q.fmt) begin
            res_hi_q <= {6'h00, res_val[9:8]}; // [RQ19] [RQ21]
            res_lo_q <= res_val[7:0];
         end else begin
            res_hi_q <= res_val[9:2]; // [RQ16] [RQ21]
            res_lo_q <= {res_val[1:0], 6'h00}; // [RQ19]
         end
      end
   end

   // Complete flag: hardware set beats a simultaneous software clear
   assign flag_clr = wr_flag && !i_hwdata[FLG_BIT];

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= done || (flag_q && !flag_clr); // [RQ12] [RQ13]
      end
   end

   assign o_irq         = flag_q && ien_q; // [RQ14]
   assign o_wake        = i_sleep && o_irq; // [RQ15]
   assign o_conv_active = (st_q == ST_CONV);

   // Analog side
   assign o_ana.chan     = ctrl0_q.chan;
   assign o_ana.temp_sel = (ctrl0_q.chan == CH_TEMP); // [RQ1] [RQ18]
   assign o_ana.fvr_sel  = (ctrl0_q.chan == CH_FVR); // [RQ18]
   // Reserved reference code falls back to supply
   assign o_ana.pref     = (ctrl1_q.pref == REF_RSVD) ? REF_VDD : ctrl1_q.pref; // [RQ7]
   assign o_ana.sample   = ctrl0_q.en && (st_q == ST_IDLE || half_q < HALF_HOLD);
   assign o_ana.code     = trial_q;

   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   logic [5:0] cyc_q;
   logic       sel_fix_q;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cyc_q     <= '0;
         sel_fix_q <= 1'b0;
      end else if (start) begin
         cyc_q     <= '0;
         sel_fix_q <= 1'b1;
      end else begin
         cyc_q <= (cyc_q == 6'h3f) ? cyc_q : cyc_q + 6'h01;
         if (wr_c1) begin
            sel_fix_q <= 1'b0;
         end
      end
   end

   property p_len;
      done && sel_fix_q && (ctrl1_q.clksel == CS_DIV2) |-> cyc_q == 6'h16;
   endproperty
   a_len: assert property (p_len) else $error("conversion length wrong"); // [RQ9]

   property p_flag_set;
      done |=> flag_q && (st_q == ST_IDLE);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [RQ12]

   property p_flag_hold;
      flag_q && !flag_clr |=> flag_q;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // [RQ13]

   property p_irq;
      done && ien_q && !wr_ien |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing"); // [RQ14]

   property p_wake;
      i_sleep && done && ien_q && rc_sel |=> o_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake"); // [RQ15]

   property p_sleep;
      (st_q == ST_CONV) && i_sleep && !rc_sel |=> (st_q == ST_IDLE) && $stable(res_hi_q);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep abort failed"); // [RQ11]

   property p_rjust;
      done && ctrl1_q.fmt |=> res_hi_q[7:2] == 6'h00;
   endproperty
   a_rjust: assert property (p_rjust) else $error("right justify"); // [RQ19]

   property p_ljust;
      done && !ctrl1_q.fmt |=> res_lo_q[5:0] == 6'h00 && res_hi_q == $past(trial_dec[9:2]);
   endproperty
   a_ljust: assert property (p_ljust) else $error("left justify"); // [RQ16]

   property p_pair;
      $changed(res_hi_q) || $changed(res_lo_q) |-> $past(res_upd);
   endproperty
   a_pair: assert property (p_pair) else $error("result torn"); // [RQ21]

   property p_temp;
      wr_c0 && (i_hwdata[C0_CHS_MSB:C0_CHS_LSB] == CH_TEMP) |=> o_ana.temp_sel && !o_ana.fvr_sel;
   endproperty
   a_temp: assert property (p_temp) else $error("temp route"); // [RQ18]

   property p_div4;
      (ctrl1_q.clksel == CS_DIV4) |-> tick == div_cnt_q[0];
   endproperty
   a_div4: assert property (p_div4) else $error("divider tap"); // [RQ22]

   c_done_rc: cover property (done && rc_sel);
   c_abort:   cover property (abort_sw && !abort_off);
   c_left:    cover property (done && !ctrl1_q.fmt);
   c_wake:    cover property (o_wake);
endmodule
`default_nettype wire

// ==== verilog/acc_pkg.sv ====
package acc_pkg;
   localparam int unsigned RES_W  = 10;
   localparam int unsigned DIV_W  = 5;
   localparam int unsigned ADDR_W = 8;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_RES_HI = 8'h08;
   localparam logic [7:0] OFS_RES_LO = 8'h0c;
   localparam logic [7:0] OFS_FLAG   = 8'h10;
   localparam logic [7:0] OFS_IEN    = 8'h14;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

   // Field positions
   localparam int unsigned C0_EN      = 0;
   localparam int unsigned C0_GO      = 1;
   localparam int unsigned C0_CHS_LSB = 2;
   localparam int unsigned C0_CHS_MSB = 6;
   localparam int unsigned C1_REF_LSB = 0;
   localparam int unsigned C1_REF_MSB = 1;
   localparam int unsigned C1_CS_LSB  = 4;
   localparam int unsigned C1_CS_MSB  = 6;
   localparam int unsigned C1_FMT     = 7;
   localparam int unsigned FLG_BIT    = 0;
   localparam int unsigned IEN_BIT    = 0;

   // Encodings
   localparam logic [4:0] CH_TEMP  = 5'h1e;
   localparam logic [4:0] CH_FVR   = 5'h1f;
   localparam logic [1:0] REF_VDD  = 2'h0;
   localparam logic [1:0] REF_RSVD = 2'h1;
   localparam logic [1:0] CS_RC    = 2'h3;
   localparam logic [2:0] CS_DIV2  = 3'h0;
   localparam logic [2:0] CS_DIV4  = 3'h4;

   // Half bit-period counts: 1.5 periods of sampling, then 10 decisions
   localparam logic [4:0] HALF_HOLD = 5'h03;
   localparam logic [4:0] HALF_DEC0 = 5'h04;
   localparam logic [4:0] HALF_LAST = 5'h16;
   localparam logic [9:0] SAR_MSB   = 10'h200;

   // Reset values
   localparam logic [4:0] RST_CHAN = 5'h00;
   localparam logic [2:0] RST_CS   = 3'h0;
   localparam logic [1:0] RST_REF  = 2'h0;
   localparam logic [7:0] RST_RES  = 8'h00;

   typedef struct packed {
      logic [4:0] chan;
      logic       en;
   } acc_ctrl0_t;

   typedef struct packed {
      logic       fmt;
      logic [2:0] clksel;
      logic [1:0] pref;
   } acc_ctrl1_t;

   typedef struct packed {
      logic [4:0] chan;
      logic       temp_sel;
      logic       fvr_sel;
      logic [1:0] pref;
      logic       sample;
      logic [9:0] code;
   } acc_ana_t;

   typedef enum logic {ST_IDLE, ST_CONV} acc_state_t;
endpackage
